/* File: verilog/smcg_pkg.sv */
package smcg_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] PSAVE_MODE_OFS = 8'h00;
  localparam logic [7:0] PSAVE_CTRL_OFS = 8'h04;
  localparam logic [7:0] SETTLE_SEL_OFS = 8'h08;
  localparam logic [7:0] CLK_SRC_OFS    = 8'h0C;
  localparam logic [7:0] STATUS_OFS     = 8'h10;
  localparam logic [7:0] WAKE_MASK_OFS  = 8'h14;
  localparam logic [7:0] RTO_BUF_OFS    = 8'h18;
  localparam logic [7:0] PORT_OFS       = 8'h1C;

  // ==========================================================
  // field positions
  localparam int STANDBY_SELECT_BIT = 0;
  localparam int STOP_REQUEST_BIT   = 0;
  localparam int SUBCLK_USED_BIT    = 0;
  localparam int WTB_SRC_WT_BIT     = 1;
  localparam int WT_SUBCLK_BIT      = 2;
  localparam int BTA_PIN_BIT        = 3;
  localparam int BTB_PIN_BIT        = 4;
  localparam int BTA_WTB_BIT        = 5;
  localparam int BTB_WTB_BIT        = 6;
  localparam int WTB_EN_BIT         = 7;
  localparam int ITB_SUBCLK_BIT     = 8;
  localparam int WD_B_SUBCLK_BIT    = 9;
  localparam int CSA_EXT_BIT        = 10;
  localparam int CSB_EXT_BIT        = 11;
  localparam int ASA_EXT_BIT        = 12;
  localparam int RTO_TRIG_BTB_BIT   = 13;
  localparam int RTO_TRIG_EN_BIT    = 14;

  // ==========================================================
  // reset values and timing
  localparam logic [31:0] CLK_SRC_RST    = 32'h0000_0000;
  localparam logic [31:0] WAKE_MASK_RST  = 32'h0000_0000;
  localparam logic [2:0]  SETTLE_SEL_RST = 3'h4;
  localparam int          SETTLE_BASE_LOG2 = 8;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0]
  {
    PM_NORMAL = 2'b00,
    PM_STOP   = 2'b01,
    PM_SETTLE = 2'b10
  } smcg_state_t;

endpackage : smcg_pkg

/* File: verilog/smcg_top.sv */
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module smcg_top
  import smcg_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        nmi_req,
  input  wire logic [7:0]  ext_irq,
  input  wire logic [7:0]  key_in,
  input  wire logic [7:0]  periph_irq,
  output logic             main_osc_en_ff,
  output logic             sub_osc_en_ff,
  output logic             cpu_clk_en_ff,
  output logic             irq_ctrl_en_ff,
  output logic             regulator_en_ff,
  output logic [13:0]      unit_clk_en_ff,
  output logic             key_wake_ff,
  output logic [15:0]      rto_buffer_ff,
  output logic [7:0]       port_out_ff,
  output logic [7:0]       port_oe_ff,
  output logic             stop_active_ff
);
  import smcg_pkg::*;

  // ==========================================================
  // register state
  smcg_state_t state_ff;
  logic        standby_select_ff;
  logic [31:0] clk_src_ff;
  logic [7:0]  wake_mask_ff;
  logic [2:0]  settle_sel_ff;
  logic [18:0] settle_cnt_ff;
  logic [7:0]  key_prev_ff;
  logic        wake_seen_ff;
  logic [7:0]  aw_addr_ff;
  logic [31:0] w_data_ff;
  logic        aw_got_ff;
  logic        w_got_ff;
  logic        w_strb0_ff;
  logic        wr_go;
  logic        stop_req;
  logic        key_edge;
  logic        wake;
  logic [18:0] settle_len;
  logic        in_stop;

  assign in_stop = (state_ff == PM_STOP);
  assign wr_go = aw_got_ff && w_got_ff && !s_axi_bvalid;
  // stop requests only land while the cpu runs (PM_NORMAL); halted cpu cannot store
  assign stop_req = wr_go && (aw_addr_ff == PSAVE_CTRL_OFS)
                    && w_data_ff[STOP_REQUEST_BIT] && standby_select_ff
                    && (state_ff == PM_NORMAL);
  assign key_edge = |(key_prev_ff & ~key_in);
  assign wake = nmi_req || key_edge
                || |((ext_irq | periph_irq) & ~wake_mask_ff);
  assign settle_len = 19'(1) << (SETTLE_BASE_LOG2 + int'(settle_sel_ff));

  // ==========================================================
  // axi4-lite write channel
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      aw_got_ff     <= 1'b0;
      w_got_ff      <= 1'b0;
      aw_addr_ff    <= 8'h00;
      w_data_ff     <= 32'h0000_0000;
      w_strb0_ff    <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_got_ff && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_got_ff && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_ff     <= 1'b1;
        aw_addr_ff    <= {s_axi_awaddr[7:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_ff     <= 1'b1;
        w_data_ff    <= s_axi_wdata;
        w_strb0_ff   <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_ff > PORT_OFS || aw_addr_ff == STATUS_OFS) ?
                        RESP_SLVERR : RESP_OKAY;
        aw_got_ff    <= 1'b0;
        w_got_ff     <= 1'b0;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // software registers; stop_req write is the last before halt
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      standby_select_ff <= 1'b0;
      clk_src_ff        <= CLK_SRC_RST;
      wake_mask_ff      <= WAKE_MASK_RST[7:0];
      settle_sel_ff     <= SETTLE_SEL_RST;
      rto_buffer_ff     <= 16'h0000;
      port_out_ff       <= 8'h00;
      port_oe_ff        <= 8'h00;
    end
    // strobe kept with the data: the master may drop it once W is taken
    else if (wr_go && !in_stop && w_strb0_ff)
    begin
      unique case (aw_addr_ff)
        PSAVE_MODE_OFS: standby_select_ff <= w_data_ff[STANDBY_SELECT_BIT];
        CLK_SRC_OFS:    clk_src_ff        <= w_data_ff;
        SETTLE_SEL_OFS: settle_sel_ff     <= w_data_ff[2:0];
        WAKE_MASK_OFS:  wake_mask_ff      <= w_data_ff[7:0];
        RTO_BUF_OFS:    rto_buffer_ff     <= w_data_ff[15:0];
        PORT_OFS:
        begin
          port_out_ff <= w_data_ff[7:0];
          port_oe_ff  <= w_data_ff[15:8];
        end
        default:        standby_select_ff <= standby_select_ff;
      endcase
    end
  end

  // ==========================================================
  // axi4-lite read channel
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= RESP_OKAY;
        unique case ({s_axi_araddr[7:2], 2'b00})
          PSAVE_MODE_OFS: s_axi_rdata <= {31'h0, standby_select_ff};
          PSAVE_CTRL_OFS: s_axi_rdata <= 32'h0000_0000;
          SETTLE_SEL_OFS: s_axi_rdata <= {29'h0, settle_sel_ff};
          CLK_SRC_OFS:    s_axi_rdata <= clk_src_ff;
          STATUS_OFS:     s_axi_rdata <= {29'h0, wake_seen_ff, state_ff};
          WAKE_MASK_OFS:  s_axi_rdata <= {24'h0, wake_mask_ff};
          RTO_BUF_OFS:    s_axi_rdata <= {16'h0, rto_buffer_ff};
          PORT_OFS:       s_axi_rdata <= {16'h0, port_oe_ff, port_out_ff};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // power-state sequencer; a reset simply restarts everything
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state_ff      <= PM_NORMAL;
      settle_cnt_ff <= 19'h0_0000;
      key_prev_ff   <= 8'hFF; // idle level of pulled-up keys
      wake_seen_ff  <= 1'b0;
    end
    else
    begin
      key_prev_ff <= key_in;
      unique case (state_ff)
        PM_NORMAL:
          if (stop_req)
            state_ff <= PM_STOP;
        PM_STOP:
          if (wake)
          begin
            state_ff      <= PM_SETTLE;
            settle_cnt_ff <= settle_len - 19'h0_0001;
            wake_seen_ff  <= 1'b1;
          end
        PM_SETTLE:
          if (settle_cnt_ff == 19'h0_0000)
            state_ff <= PM_NORMAL;
          else
            settle_cnt_ff <= settle_cnt_ff - 19'h0_0001;
        default:
          state_ff <= PM_NORMAL;
      endcase
      if (stop_req)
        wake_seen_ff <= 1'b0;
    end
  end

  // ==========================================================
  // clock gates; ports and data untouched so they hold
  logic       sub;
  logic       stop_nxt;
  logic       wtb_runs;
  logic [1:0] bt_runs;
  logic [13:0] nxt_unit;

  assign stop_nxt = (state_ff == PM_NORMAL) ? stop_req : (state_ff == PM_STOP && !wake);
  assign sub = clk_src_ff[SUBCLK_USED_BIT];
  assign wtb_runs = sub && clk_src_ff[WTB_SRC_WT_BIT] && clk_src_ff[WT_SUBCLK_BIT]
                    && clk_src_ff[WTB_EN_BIT];
  assign bt_runs[0] = clk_src_ff[BTA_PIN_BIT]
                      || (clk_src_ff[BTA_WTB_BIT] && wtb_runs);
  assign bt_runs[1] = clk_src_ff[BTB_PIN_BIT]
                      || (clk_src_ff[BTB_WTB_BIT] && wtb_runs);

  always_comb
  begin
    nxt_unit     = 14'h3FFF;
    if (stop_nxt)
    begin
      nxt_unit[0]  = 1'b0; // wide timer a
      nxt_unit[1]  = wtb_runs;
      nxt_unit[2]  = bt_runs[0];
      nxt_unit[3]  = bt_runs[1];
      nxt_unit[4]  = 1'b0; // interval timer a
      nxt_unit[5]  = sub && clk_src_ff[ITB_SUBCLK_BIT];
      nxt_unit[6]  = sub && clk_src_ff[WT_SUBCLK_BIT];
      nxt_unit[7]  = 1'b0; // watchdog a
      nxt_unit[8]  = sub && clk_src_ff[WD_B_SUBCLK_BIT];
      nxt_unit[9]  = clk_src_ff[CSA_EXT_BIT];
      nxt_unit[10] = clk_src_ff[CSB_EXT_BIT];
      nxt_unit[11] = clk_src_ff[ASA_EXT_BIT];
      // converter assumed already disabled by software
      nxt_unit[12] = 1'b0; // auto serial, two-wire, async b, converter
      nxt_unit[13] = clk_src_ff[RTO_TRIG_EN_BIT]
                     && bt_runs[clk_src_ff[RTO_TRIG_BTB_BIT]];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      main_osc_en_ff  <= 1'b1;
      sub_osc_en_ff   <= 1'b0;
      cpu_clk_en_ff   <= 1'b1;
      irq_ctrl_en_ff  <= 1'b1;
      regulator_en_ff <= 1'b1;
      unit_clk_en_ff  <= 14'h3FFF;
      key_wake_ff     <= 1'b0;
      stop_active_ff  <= 1'b0;
    end
    else
    begin
      main_osc_en_ff  <= !stop_nxt;
      cpu_clk_en_ff   <= (state_ff == PM_NORMAL) && !stop_req;
      irq_ctrl_en_ff  <= !stop_nxt;
      regulator_en_ff <= !stop_nxt;
      sub_osc_en_ff   <= sub;
      unit_clk_en_ff  <= nxt_unit;
      key_wake_ff     <= key_edge;
      stop_active_ff  <= stop_nxt;
    end
  end

endmodule : smcg_top

/* File: verif/smcg_sva.sv */
`timescale 1ns/1ps
// ========
// stop mode checker
module smcg_sva
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        nmi_req,
  input wire logic [7:0]  ext_irq,
  input wire logic [7:0]  periph_irq,
  input wire logic [7:0]  key_in,
  input wire logic        main_osc_en_ff,
  input wire logic        sub_osc_en_ff,
  input wire logic        cpu_clk_en_ff,
  input wire logic        irq_ctrl_en_ff,
  input wire logic        regulator_en_ff,
  input wire logic [13:0] unit_clk_en_ff,
  input wire logic        key_wake_ff,
  input wire logic [15:0] rto_buffer_ff,
  input wire logic [7:0]  port_out_ff,
  input wire logic [7:0]  port_oe_ff,
  input wire logic        stop_active_ff
);
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  clk_off_a: assert property
    (stop_active_ff |-> !cpu_clk_en_ff && !main_osc_en_ff) else $error("clock on in stop");
  core_off_a: assert property
    (stop_active_ff |-> !irq_ctrl_en_ff && !regulator_en_ff) else $error("core on in stop");
  fixed_units_a: assert property
    (stop_active_ff |-> (unit_clk_en_ff & 14'h1091) == 14'h0000) else $error("unit on");
  no_subclk_a: assert property
    (stop_active_ff && !sub_osc_en_ff |-> (unit_clk_en_ff & 14'h0162) == 14'h0000)
    else $error("subclock unit on");
  port_hold_a: assert property
    (stop_active_ff ##1 stop_active_ff |-> $stable({port_out_ff, port_oe_ff}))
    else $error("port moved");
  rto_hold_a: assert property
    (stop_active_ff ##1 stop_active_ff |-> $stable(rto_buffer_ff)) else $error("rto moved");
  key_pulse_a: assert property
    (stop_active_ff && |($past(key_in) & ~key_in) |-> ##[0:2] key_wake_ff)
    else $error("key edge lost");
  nmi_wake_a: assert property
    (stop_active_ff && nmi_req |-> ##[1:2] !stop_active_ff) else $error("nmi no wake");
  // quiet spans three cycles as wake inputs may be registered first
  stay_asleep_a: assert property
    ((stop_active_ff && !nmi_req && ext_irq == 8'h00 && periph_irq == 8'h00
      && $stable(key_in)) [*3] |=> stop_active_ff) else $error("woke alone");
endmodule : smcg_sva

bind smcg_top smcg_sva u_sva
(
  .ref_clk, .rst_n, .nmi_req, .ext_irq, .periph_irq, .key_in, .main_osc_en_ff,
  .sub_osc_en_ff, .cpu_clk_en_ff, .irq_ctrl_en_ff, .regulator_en_ff,
  .unit_clk_en_ff, .key_wake_ff, .rto_buffer_ff, .port_out_ff, .port_oe_ff,
  .stop_active_ff
);

/* File: verif/smcg_wake_src.sv */
`timescale 1ns/1ps
// ========
// wake sources beside the block
module smcg_wake_src
(
  input  wire logic       fire,
  input  wire logic [1:0] kind,
  output logic            nmi_req,
  output logic [7:0]      ext_irq,
  output logic [7:0]      periph_irq,
  output logic [7:0]      key_in
);
  // requests are levels held while fire stands; keys idle high as pulled-up pins
  assign nmi_req    = fire && kind == 2'h0;
  assign ext_irq    = {7'h00, fire && kind == 2'h1};
  assign periph_irq = {7'h00, fire && kind == 2'h2};
  assign key_in     = {7'h7F, !(fire && kind == 2'h3)};
endmodule : smcg_wake_src

/* File: verif/smcg_tb_top.sv */
`timescale 1ns/1ps
module smcg_tb_top;
  import smcg_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, fire = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  kind = 2'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        nmi_req, main_osc_en_ff, sub_osc_en_ff, cpu_clk_en_ff, irq_ctrl_en_ff;
  logic        regulator_en_ff, key_wake_ff, stop_active_ff;
  logic [7:0]  ext_irq, key_in, periph_irq, port_out_ff, port_oe_ff;
  logic [13:0] unit_clk_en_ff;
  logic [15:0] rto_buffer_ff;
  logic [31:0] cfg [4] = '{32'h140D, 32'h6BC7, 32'h03A6, 32'h541D};
  logic [13:0] exp_en [4] = '{14'h0A44, 14'h256A, 14'h0000, 14'h2A4C};
  logic [1:0]  kd [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  int          n_fail = 0, checks = 0;

  initial forever #12.5 ref_clk = ~ref_clk;

  smcg_top DUT
  (
    .ref_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .nmi_req, .ext_irq, .key_in,
    .periph_irq, .main_osc_en_ff, .sub_osc_en_ff, .cpu_clk_en_ff, .irq_ctrl_en_ff,
    .regulator_en_ff, .unit_clk_en_ff, .key_wake_ff, .rto_buffer_ff, .port_out_ff,
    .port_oe_ff, .stop_active_ff
  );
  smcg_wake_src u_src (.fire, .kind, .nmi_req, .ext_irq, .periph_irq, .key_in);

  // ========
  // tasks
  task automatic stop_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] e);
    checks++;
    if (seen !== e)
    begin
      n_fail++;
      $display("ERROR %0t: got %h want %h", $time, seen, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = RESP_OKAY);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 40; n++)
    begin
      @(posedge ref_clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(r));
        @(posedge ref_clk);
        return;
      end
    end
    n_fail++;
    stop_test();
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r,
                       input logic [31:0] m = 32'hFFFF_FFFF);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 40; n++)
    begin
      @(posedge ref_clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata & m, e);
        chk(32'(s_axi_rresp), 32'(r));
        @(posedge ref_clk);
        return;
      end
    end
    n_fail++;
    stop_test();
  endtask : rdchk

  // converter enables have no place in this block, so nothing to clear first
  task automatic enter_stop;
    wr(PSAVE_MODE_OFS, 32'h1);
    wr(PSAVE_CTRL_OFS, 32'h1);
    repeat (3) @(posedge ref_clk);
  endtask : enter_stop

  task automatic wake(input logic [1:0] k);
    kind <= k;
    fire <= 1'b1;
    repeat (4) @(posedge ref_clk);
    fire <= 1'b0;
    @(posedge ref_clk);
  endtask : wake

  // ========
  // sequence
  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rdchk(SETTLE_SEL_OFS, 32'(SETTLE_SEL_RST), RESP_OKAY);
    rdchk(CLK_SRC_OFS, CLK_SRC_RST, RESP_OKAY);
    rdchk(8'h20, 32'h0, RESP_SLVERR);
    wr(PSAVE_CTRL_OFS, 32'h1);
    repeat (3) @(posedge ref_clk);
    chk(32'({stop_active_ff, cpu_clk_en_ff}), 32'h1);
    wr(SETTLE_SEL_OFS, 32'h0);
    wr(RTO_BUF_OFS, 32'h1234);
    wr(PORT_OFS, 32'hC35A);
    wr(STATUS_OFS, 32'h0, RESP_SLVERR);
    wr(8'h20, 32'h0, RESP_SLVERR);
    s_axi_wstrb <= 4'h0;
    wr(WAKE_MASK_OFS, 32'h0000_00FF);
    s_axi_wstrb <= 4'hF;
    rdchk(WAKE_MASK_OFS, WAKE_MASK_RST, RESP_OKAY);
    $display("test setup done");
    for (int i = 0; i < 4; i++)
    begin
      wr(CLK_SRC_OFS, cfg[i]);
      enter_stop();
      chk(32'({stop_active_ff, cpu_clk_en_ff, main_osc_en_ff, irq_ctrl_en_ff,
               regulator_en_ff}), 32'h10);
      chk(32'(unit_clk_en_ff), 32'(exp_en[i]));
      chk(32'(sub_osc_en_ff), 32'(cfg[i][0]));
      rdchk(STATUS_OFS, 32'h1, RESP_OKAY, 32'h3);
      wr(RTO_BUF_OFS, 32'hFFFF);
      wake(kd[i]);
      rdchk(STATUS_OFS, 32'h2, RESP_OKAY, 32'h3);
      repeat (190) @(posedge ref_clk);
      rdchk(STATUS_OFS, 32'h2, RESP_OKAY, 32'h3);
      repeat (60) @(posedge ref_clk);
      rdchk(STATUS_OFS, 32'h4, RESP_OKAY);
      rdchk(CLK_SRC_OFS, cfg[i], RESP_OKAY);
      chk({rto_buffer_ff, port_oe_ff, port_out_ff}, 32'h1234_C35A);
      chk(32'({unit_clk_en_ff, cpu_clk_en_ff, main_osc_en_ff, irq_ctrl_en_ff,
               regulator_en_ff}), 32'h3FFFF);
      $display("test wake %0d done", i);
    end
    wr(WAKE_MASK_OFS, 32'hFFFF_FFFF);
    enter_stop();
    wake(2'h1);
    wake(2'h2);
    chk(32'(stop_active_ff), 32'h1);
    rst_n <= 1'b0;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    chk(32'({stop_active_ff, cpu_clk_en_ff, sub_osc_en_ff}), 32'h2);
    rdchk(WAKE_MASK_OFS, WAKE_MASK_RST, RESP_OKAY);
    rdchk(STATUS_OFS, 32'h0, RESP_OKAY);
    $display("test masked and reset done");
    stop_test();
  end
endmodule : smcg_tb_top
